// ---- hdl/ckh_regs.svh ----
// Purpose: register map, field positions and link counts of the codec keyhole block
// Assumes: bit 31 of the bus word is its least significant bit (data[0])
// Notes:   Functional notes follow
//
// Functional notes
// - writing 1 to clear-register bit 30 resets record FIFO and its overrun flag
// - writing 1 to clear-register bit 31 resets playback FIFO and its underrun flag
// - command register bits 24..30 hold the 7-bit codec register address
// - command bit 31 at 0 writes codec register with the preloaded write value
// - command bit 31 at 1 sends a read command for the addressed register
// - finished flag goes high once the codec access has completed
// - result register returns last codec read data, valid while finished flag set
// - write-value register holds data for the next codec write command
// - status bit 27 reads 0 while access pending and 1 once finished
// - status bits 24/25 flag overrun/underrun and stay set until FIFO reset
`ifndef CKH_REGS_SVH
`define CKH_REGS_SVH

`define CKH_OFS_STATUS   5'h08
`define CKH_OFS_CLEAR    5'h0C
`define CKH_OFS_CMD      5'h10
`define CKH_OFS_RESULT   5'h14
`define CKH_OFS_WVALUE   5'h18

// big-endian bit n of the bus is data[31-n]
`define CKH_BIT_REC_CLR  1
`define CKH_BIT_PLAY_CLR 0
`define CKH_BIT_CMD_RD   0
`define CKH_ST_REC_OVR   7
`define CKH_ST_PLAY_UND  6
`define CKH_ST_DONE      4
`define CKH_FLD_ADDR     7:1
`define CKH_FLD_BYTE     7:0

`define CKH_CMD_BITS     5'h10
`define CKH_RX_BITS      5'h08
`define CKH_SYNC_LAT     5'h02

`endif

// ---- hdl/ckh_pkg.sv ----
// Purpose: state types of the codec keyhole block
// Assumes: nothing beyond SystemVerilog 2012
// Notes:   one struct per clock domain
package ckh_pkg;

    typedef enum logic [1:0] {CKH_IDLE, CKH_SEND, CKH_RECV} ckh_link_st_t;

    typedef struct packed {
        logic [6:0]  cmd_addr;
        logic        cmd_rd;
        logic [7:0]  wvalue;
        logic [7:0]  result;
        logic        done;
        logic        rec_ovr;
        logic        play_und;
        logic        req_tgl;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_s3;
        logic        rec_rst;
        logic        play_rst;
        logic        bus_ack;
        logic [31:0] bus_rdata;
    } ckh_host_t;

    typedef struct packed {
        ckh_link_st_t st;
        logic [4:0]   cnt;
        logic [15:0]  sh_out;
        logic [7:0]   sh_in;
        logic [7:0]   rdata;
        logic         req_s1;
        logic         req_s2;
        logic         req_s3;
        logic         ack_tgl;
        logic         rx_s1;
        logic         rx_s2;
        logic         sync;
        logic         sdo;
    } ckh_link_t;

endpackage : ckh_pkg

// ---- hdl/ckh_top.sv ----
// Purpose: keyhole access to codec registers plus FIFO clear and error flags
// Assumes: single-cycle bus strobes; host clock at least twice the bit clock
// Notes:   command fields are quasi-static while an access is pending
`timescale 1ns/1ps
`include "ckh_regs.svh"

module ckh_top
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        BUS_SEL,
    input  wire logic        BUS_WR,
    input  wire logic [4:0]  BUS_ADDR,
    input  wire logic [31:0] BUS_WDATA,
    output logic      [31:0] BUS_RDATA,
    output logic             BUS_ACK,
    input  wire logic        REC_OVERRUN_EVT,
    input  wire logic        PLAY_UNDERRUN_EVT,
    output logic             REC_FIFO_RST,
    output logic             PLAY_FIFO_RST,
    input  wire logic        BIT_CLK,
    output logic             CODEC_SYNC,
    output logic             CODEC_SDO,
    input  wire logic        CODEC_SDI
);

    ckh_pkg::ckh_host_t h_reg;
    ckh_pkg::ckh_host_t h_next;
    ckh_pkg::ckh_link_t l_reg;
    ckh_pkg::ckh_link_t l_next;

    logic wr_stb;
    logic rd_stb;
    logic busy;
    logic ack_edge;
    logic wr_clear;
    logic wr_cmd;

    assign wr_stb   = BUS_SEL && BUS_WR;
    assign rd_stb   = BUS_SEL && !BUS_WR;
    assign busy     = h_reg.req_tgl != h_reg.ack_s3;
    assign ack_edge = h_reg.ack_s2 != h_reg.ack_s3;
    assign wr_clear = wr_stb && BUS_ADDR == `CKH_OFS_CLEAR;
    // a launch while busy would lose a toggle, so it is dropped whole
    assign wr_cmd   = wr_stb && BUS_ADDR == `CKH_OFS_CMD && !busy;

    ////////////////////////////////////////////////////////////////////////////
    // host domain

    always_comb
    begin
        h_next          = h_reg;
        h_next.ack_s1   = l_reg.ack_tgl;
        h_next.ack_s2   = h_reg.ack_s1;
        h_next.ack_s3   = h_reg.ack_s2;
        h_next.rec_rst  = 1'b0;
        h_next.play_rst = 1'b0;
        h_next.bus_ack  = BUS_SEL;
        h_next.bus_rdata = 32'h0000_0000;
        if (wr_clear && BUS_WDATA[`CKH_BIT_REC_CLR])
        begin
            h_next.rec_rst = 1'b1;
            h_next.rec_ovr = 1'b0;
        end
        if (wr_clear && BUS_WDATA[`CKH_BIT_PLAY_CLR])
        begin
            h_next.play_rst = 1'b1;
            h_next.play_und = 1'b0;
        end
        // events win over a clear in the same cycle
        if (REC_OVERRUN_EVT)
            h_next.rec_ovr = 1'b1;
        if (PLAY_UNDERRUN_EVT)
            h_next.play_und = 1'b1;
        if (wr_stb && BUS_ADDR == `CKH_OFS_WVALUE)
            h_next.wvalue = BUS_WDATA[`CKH_FLD_BYTE];
        if (wr_cmd)
        begin
            h_next.cmd_addr = BUS_WDATA[`CKH_FLD_ADDR];
            h_next.cmd_rd   = BUS_WDATA[`CKH_BIT_CMD_RD];
            h_next.done     = 1'b0;
            h_next.req_tgl  = !h_reg.req_tgl;
        end
        if (ack_edge)
        begin
            h_next.done   = 1'b1;
            h_next.result = l_reg.rdata;
        end
        if (rd_stb)
        begin
            case (BUS_ADDR)
                `CKH_OFS_STATUS:
                begin
                    h_next.bus_rdata[`CKH_ST_REC_OVR]  = h_reg.rec_ovr;
                    h_next.bus_rdata[`CKH_ST_PLAY_UND] = h_reg.play_und;
                    h_next.bus_rdata[`CKH_ST_DONE]     = h_reg.done;
                end
                `CKH_OFS_RESULT:
                    h_next.bus_rdata[`CKH_FLD_BYTE] = h_reg.result;
                default:
                    h_next.bus_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            h_reg <= '0;
        else
            h_reg <= h_next;
    end

    assign BUS_RDATA     = h_reg.bus_rdata;
    assign BUS_ACK       = h_reg.bus_ack;
    assign REC_FIFO_RST  = h_reg.rec_rst;
    assign PLAY_FIFO_RST = h_reg.play_rst;

    ////////////////////////////////////////////////////////////////////////////
    // link domain

    always_comb
    begin
        l_next        = l_reg;
        l_next.req_s1 = h_reg.req_tgl;
        l_next.req_s2 = l_reg.req_s1;
        l_next.req_s3 = l_reg.req_s2;
        l_next.rx_s1  = CODEC_SDI;
        l_next.rx_s2  = l_reg.rx_s1;
        case (l_reg.st)
            ckh_pkg::CKH_IDLE:
            begin
                if (l_reg.req_s2 != l_reg.req_s3)
                begin
                    // read frames carry zero data bits
                    l_next.sh_out = {h_reg.cmd_rd, h_reg.cmd_addr,
                                     h_reg.cmd_rd ? 8'h00 : h_reg.wvalue};
                    l_next.sdo    = h_reg.cmd_rd;
                    l_next.sh_out = {l_next.sh_out[14:0], 1'b0};
                    l_next.sync   = 1'b1;
                    l_next.cnt    = `CKH_CMD_BITS - 5'h01;
                    l_next.st     = ckh_pkg::CKH_SEND;
                end
            end
            ckh_pkg::CKH_SEND:
            begin
                if (l_reg.cnt == 5'h00)
                begin
                    l_next.sync = 1'b0;
                    l_next.sdo  = 1'b0;
                    if (h_reg.cmd_rd)
                    begin
                        l_next.cnt = `CKH_RX_BITS + `CKH_SYNC_LAT - 5'h01;
                        l_next.st  = ckh_pkg::CKH_RECV;
                    end
                    else
                    begin
                        l_next.ack_tgl = !l_reg.ack_tgl;
                        l_next.st      = ckh_pkg::CKH_IDLE;
                    end
                end
                else
                begin
                    l_next.sdo    = l_reg.sh_out[15];
                    l_next.sh_out = {l_reg.sh_out[14:0], 1'b0};
                    l_next.cnt    = l_reg.cnt - 5'h01;
                end
            end
            ckh_pkg::CKH_RECV:
            begin
                // two extra counts cover the input synchroniser delay
                l_next.sh_in = {l_reg.sh_in[6:0], l_reg.rx_s2};
                l_next.cnt   = l_reg.cnt - 5'h01;
                if (l_reg.cnt == 5'h00)
                begin
                    l_next.rdata   = {l_reg.sh_in[6:0], l_reg.rx_s2};
                    l_next.ack_tgl = !l_reg.ack_tgl;
                    l_next.st      = ckh_pkg::CKH_IDLE;
                end
            end
            default:
                l_next.st = ckh_pkg::CKH_IDLE;
        endcase
    end

    always_ff @(posedge BIT_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            l_reg <= '0;
        else
            l_reg <= l_next;
    end

    assign CODEC_SYNC = l_reg.sync;
    assign CODEC_SDO  = l_reg.sdo;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_cmd_write;
        wr_cmd;
    endsequence

    sequence s_ack_seen;
        ack_edge ##1 h_reg.done;
    endsequence

    property p_rec_clr;
        @(posedge CLK) disable iff (!ARST_N)
        wr_clear && BUS_WDATA[`CKH_BIT_REC_CLR] && !REC_OVERRUN_EVT
            |=> REC_FIFO_RST && !h_reg.rec_ovr;
    endproperty
    a_rec_clr: assert property (p_rec_clr) else $error("record clear failed");

    property p_play_clr;
        @(posedge CLK) disable iff (!ARST_N)
        wr_clear && !BUS_WDATA[`CKH_BIT_PLAY_CLR] |=> !PLAY_FIFO_RST;
    endproperty
    a_play_clr: assert property (p_play_clr) else $error("playback reset spurious");

    property p_cmd_addr;
        @(posedge CLK) disable iff (!ARST_N)
        s_cmd_write |=> h_reg.cmd_addr == $past(BUS_WDATA[`CKH_FLD_ADDR]);
    endproperty
    a_cmd_addr: assert property (p_cmd_addr) else $error("address not held");

    property p_done_clr;
        @(posedge CLK) disable iff (!ARST_N)
        s_cmd_write |=> !h_reg.done && busy;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("launch did not clear flag");

    property p_wr_data;
        @(posedge BIT_CLK) disable iff (!ARST_N)
        $rose(CODEC_SYNC) && !h_reg.cmd_rd |-> ##8 CODEC_SDO == h_reg.wvalue[7];
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data bit wrong");

    property p_rd_cmd;
        @(posedge BIT_CLK) disable iff (!ARST_N)
        $rose(CODEC_SYNC) |-> CODEC_SDO == h_reg.cmd_rd ##1 CODEC_SYNC [*8];
    endproperty
    a_rd_cmd: assert property (p_rd_cmd) else $error("command bit wrong");

    property p_done_set;
        @(posedge CLK) disable iff (!ARST_N)
        $fell(busy) |-> h_reg.done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("finished flag missing");

    property p_result;
        @(posedge CLK) disable iff (!ARST_N)
        s_ack_seen |-> h_reg.result == l_reg.rdata;
    endproperty
    a_result: assert property (p_result) else $error("result not captured");

    property p_status_done;
        @(posedge CLK) disable iff (!ARST_N)
        rd_stb && BUS_ADDR == `CKH_OFS_STATUS |=> BUS_RDATA[`CKH_ST_DONE] == $past(h_reg.done);
    endproperty
    a_status_done: assert property (p_status_done) else $error("status bit 27 wrong");

    property p_sticky;
        @(posedge CLK) disable iff (!ARST_N)
        h_reg.rec_ovr && !(wr_clear && BUS_WDATA[`CKH_BIT_REC_CLR]) |=> h_reg.rec_ovr;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overrun flag lost");

    property p_wo_zero;
        @(posedge CLK) disable iff (!ARST_N)
        rd_stb && (BUS_ADDR == `CKH_OFS_CMD || BUS_ADDR == `CKH_OFS_WVALUE)
            |=> BUS_RDATA == 32'h0000_0000;
    endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("write-only read nonzero");

    property p_play_set;
        @(posedge CLK) disable iff (!ARST_N)
        wr_clear && BUS_WDATA[`CKH_BIT_PLAY_CLR] && !PLAY_UNDERRUN_EVT
            |=> PLAY_FIFO_RST && !h_reg.play_und;
    endproperty
    a_play_set: assert property (p_play_set) else $error("playback clear failed");

    // an event must land even when a clear arrives in the same cycle
    property p_ovr_set;
        @(posedge CLK) disable iff (!ARST_N)
        REC_OVERRUN_EVT |=> h_reg.rec_ovr;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun event lost");

    property p_und_set;
        @(posedge CLK) disable iff (!ARST_N)
        PLAY_UNDERRUN_EVT |=> h_reg.play_und;
    endproperty
    a_und_set: assert property (p_und_set) else $error("underrun event lost");

    property p_und_sticky;
        @(posedge CLK) disable iff (!ARST_N)
        h_reg.play_und && !(wr_clear && BUS_WDATA[`CKH_BIT_PLAY_CLR]) |=> h_reg.play_und;
    endproperty
    a_und_sticky: assert property (p_und_sticky) else $error("underrun flag lost");

    property p_wvalue;
        @(posedge CLK) disable iff (!ARST_N)
        wr_stb && BUS_ADDR == `CKH_OFS_WVALUE
            |=> h_reg.wvalue == $past(BUS_WDATA[`CKH_FLD_BYTE]);
    endproperty
    a_wvalue: assert property (p_wvalue) else $error("write value not held");

endmodule : ckh_top

// ---- dv/ckh_codec_model.sv ----
// Purpose: behavioural codec at the far end of the keyhole link
// Assumes: command frame {rd, addr[6:0], data[7:0]} MSB first while sync is high
// Notes:   register contents start at zero; testbench may preload them
`timescale 1ns/1ps

module ckh_codec_model
(
    input  wire logic bit_clk,
    input  wire logic sync,
    input  wire logic sdo,
    output logic      sdi
);
    logic [7:0]  regs [128];
    logic [15:0] frame;
    logic [7:0]  rdv;
    int          bits;
    int          frames;
    int          tx;

    initial
    begin
        sdi    = 1'b0;
        bits   = 0;
        frames = 0;
        tx     = 0;
        frame  = 16'h0000;
        rdv    = 8'h00;
        foreach (regs[i]) regs[i] = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample mid-bit on the falling edge; idle line toggles so no stale value lingers
    always @(negedge bit_clk)
    begin
        if (sync === 1'b1)
        begin
            frame = {frame[14:0], sdo};
            bits++;
            if (bits == 16)
            begin
                bits = 0;
                frames++;
                if (frame[15])
                begin
                    rdv = regs[frame[14:8]];
                    tx  = 8;
                end
                else
                begin
                    regs[frame[14:8]] = frame[7:0];
                end
            end
            sdi = ~sdi;
        end
        else if (tx != 0)
        begin
            bits = 0;
            sdi  = rdv[tx-1];
            tx--;
        end
        else
        begin
            bits = 0;
            sdi  = ~sdi;
        end
    end

endmodule : ckh_codec_model

// ---- dv/audio_codec_keyhole_access_tb.sv ----
// Purpose: self-checking bench for the codec keyhole block
// Assumes: inputs change on the falling host clock edge
// Notes:   reset spans 2 host cycles; one bit clock edge falls inside it
`timescale 1ns/1ps
`include "ckh_regs.svh"

module audio_codec_keyhole_access_tb;
    logic        clk = 1'b0;
    logic        bit_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sel = 1'b0;
    logic        wr = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        rec_evt = 1'b0;
    logic        play_evt = 1'b0;
    logic [31:0] rdata;
    logic        ack;
    logic        rec_rst;
    logic        play_rst;
    logic        sync;
    logic        sdo;
    logic        sdi;
    logic [31:0] q;
    int          failures = 0;
    int          check_count = 0;
    int          rec_pulses = 0;
    int          play_pulses = 0;

    localparam logic [31:0] OVR  = 32'h1 << `CKH_ST_REC_OVR;
    localparam logic [31:0] UND  = 32'h1 << `CKH_ST_PLAY_UND;
    localparam logic [31:0] DONE = 32'h1 << `CKH_ST_DONE;

    always #10 clk = ~clk;
    always #24 bit_clk = ~bit_clk;

    ckh_top DUT (.CLK(clk), .ARST_N(arst_n), .BUS_SEL(sel), .BUS_WR(wr), .BUS_ADDR(addr),
        .BUS_WDATA(wdata), .BUS_RDATA(rdata), .BUS_ACK(ack), .REC_OVERRUN_EVT(rec_evt),
        .PLAY_UNDERRUN_EVT(play_evt), .REC_FIFO_RST(rec_rst), .PLAY_FIFO_RST(play_rst),
        .BIT_CLK(bit_clk), .CODEC_SYNC(sync), .CODEC_SDO(sdo), .CODEC_SDI(sdi));

    ckh_codec_model codec (.bit_clk(bit_clk), .sync(sync), .sdo(sdo), .sdi(sdi));

    always @(posedge clk)
    begin
        if (rec_rst === 1'b1) rec_pulses++;
        if (play_rst === 1'b1) play_pulses++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one-cycle strobe; ack and read data stand in the following cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(negedge clk);
        sel = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        sel = 1'b0;
        wr = 1'b0;
        check("ack", {31'h0, ack}, 32'h1);
        q = rdata;
    endtask : bus

    task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask : rd

    task automatic wait_done();
        for (int i = 0; i < 200; i++)
        begin
            bus(1'b0, `CKH_OFS_STATUS, 32'h0);
            if (q[`CKH_ST_DONE] === 1'b1) break;
        end
        check("finished flag", q & DONE, DONE);
    endtask : wait_done

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rd("status", `CKH_OFS_STATUS, 32'h0);
        rd("clear reg", `CKH_OFS_CLEAR, 32'h0);
        rd("cmd reg", `CKH_OFS_CMD, 32'h0);
        rd("wvalue reg", `CKH_OFS_WVALUE, 32'h0);
        rd("unmapped", 5'h1C, 32'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_flags();
        @(negedge clk);
        rec_evt = 1'b1;
        play_evt = 1'b1;
        @(negedge clk);
        rec_evt = 1'b0;
        play_evt = 1'b0;
        rd("both flags", `CKH_OFS_STATUS, OVR | UND);
        bus(1'b1, `CKH_OFS_CLEAR, 32'hFFFF_FFFC);
        rd("flags kept", `CKH_OFS_STATUS, OVR | UND);
        check("no resets", rec_pulses + play_pulses, 32'h0);
        bus(1'b1, `CKH_OFS_CLEAR, 32'h0000_0002);
        check("rec pulse high", {31'h0, rec_rst}, 32'h1);
        // the pulse counter ticks at the next rising edge
        @(negedge clk);
        check("rec pulse", rec_pulses, 32'h1);
        check("rec pulse low", {31'h0, rec_rst}, 32'h0);
        rd("rec cleared", `CKH_OFS_STATUS, UND);
        bus(1'b1, `CKH_OFS_CLEAR, 32'h0000_0001);
        check("play pulse high", {31'h0, play_rst}, 32'h1);
        @(negedge clk);
        check("play pulse", play_pulses, 32'h1);
        rd("play cleared", `CKH_OFS_STATUS, 32'h0);
        // overrun in the clearing cycle must survive the clear
        @(negedge clk);
        sel = 1'b1;
        wr = 1'b1;
        addr = `CKH_OFS_CLEAR;
        wdata = 32'h0000_0002;
        rec_evt = 1'b1;
        @(negedge clk);
        sel = 1'b0;
        wr = 1'b0;
        rec_evt = 1'b0;
        check("clear beside event", {31'h0, rec_rst}, 32'h1);
        rd("event wins", `CKH_OFS_STATUS, OVR);
        bus(1'b1, `CKH_OFS_CLEAR, 32'h0000_0002);
        rd("rec cleared again", `CKH_OFS_STATUS, 32'h0);
        $display("test_flags done");
    endtask : test_flags

    // outside-field bits set on purpose; only the low byte fields may matter
    task automatic test_write();
        bus(1'b1, `CKH_OFS_WVALUE, 32'hABCD_EF5A);
        bus(1'b1, `CKH_OFS_CMD, 32'hFFFF_FF24);
        wait_done();
        check("codec reg", codec.regs[7'h12], 32'h5A);
        check("write frame", codec.frame, 32'h125A);
        check("frames", codec.frames, 32'h1);
        $display("test_write done");
    endtask : test_write

    task automatic test_read();
        codec.regs[7'h33] = 8'hC3;
        bus(1'b1, `CKH_OFS_CMD, 32'h0000_0067);
        rd("flag cleared", `CKH_OFS_STATUS, 32'h0);
        bus(1'b1, `CKH_OFS_CMD, 32'h0000_0024);
        wait_done();
        rd("result", `CKH_OFS_RESULT, 32'h0000_00C3);
        check("read frame", codec.frame, 32'hB300);
        check("frames", codec.frames, 32'h2);
        rd("flag stands", `CKH_OFS_STATUS, DONE);
        $display("test_read done");
    endtask : test_read

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        test_reset();
        test_flags();
        test_write();
        test_read();
        complete_run();
    end

    // whole run needs a few microseconds; this cuts a hang short
    initial
    begin
        #50us;
        failures++;
        $display("watchdog expired");
        complete_run();
    end

endmodule : audio_codec_keyhole_access_tb
